// File: rtl/pwm_gen.v
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.vh"

// =====================================================
// Prescaled 16-bit pulse width generator, APB slave
// =====================================================
module pwm_gen #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input  wire              MCLK_I,
	input  wire              RSTN_I,
	// APB slave
	input  wire              PSEL_I,
	input  wire              PENABLE_I,
	input  wire              PWRITE_I,
	input  wire [ADDR_W-1:0] PADDR_I,
	input  wire [31:0]       PWDATA_I,
	output wire [31:0]       PRDATA_O,
	output wire              PREADY_O,
	output wire              PSLVERR_O,
	// Waveform and request
	output wire              PWM_O,
	output wire              IRQ_O
);

	// =====================================================
	// Reset synchroniser
	// =====================================================
	reg         rst_meta_r;        // First stage, read only by second
	reg         rst_n_r;           // Released reset used everywhere

	// Asynchronous assert, clocked release
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// =====================================================
	// Declarations
	// =====================================================
	reg  [7:0]  control_r;         // Waveform control register
	reg  [7:0]  period_high_r;     // Stored period high byte
	reg  [7:0]  period_low_r;      // Stored period low byte
	reg  [7:0]  pulse_high_r;      // Stored pulse width high byte
	reg  [7:0]  pulse_low_r;       // Stored pulse width low byte
	reg  [1:0]  period_seen_r;     // Bytes of period written: {high,low}
	reg  [1:0]  pulse_seen_r;      // Bytes of pulse width written
	reg  [15:0] period_stage_r;    // Complete period waiting for wrap
	reg  [15:0] pulse_stage_r;     // Complete pulse width waiting for wrap
	reg         period_pend_r;     // Staged period is pending
	reg         pulse_pend_r;      // Staged pulse width is pending
	reg  [15:0] period_act_r;      // Period used by the running cycle
	reg  [15:0] pulse_act_r;       // Pulse width used by the running cycle
	reg  [15:0] count_r;           // Waveform counter
	reg         en_d_r;            // Enable seen last cycle
	reg         pwm_r;             // Registered waveform
	reg         irq_r;             // Pending interrupt request
	reg  [31:0] prdata_r;          // Read data, captured at setup
	reg         pready_r;          // Ready for the access phase
	reg         pslverr_r;         // Error for unmapped address
	reg  [7:0]  rdata_nxt;         // Read mux
	reg         hit_nxt;           // Address maps to a register
	reg         pwm_nxt;           // Next waveform level

	wire        enable;            // Waveform enable bit
	wire        int_enable;        // Interrupt enable bit
	wire [2:0]  div_sel;           // Divider select field
	wire        tick;              // Prescaled counting tick
	wire        setup;             // APB setup cycle
	wire        wr_done;           // Write takes effect this edge
	wire [7:0]  wr_idx;            // Register index of the access
	wire [7:0]  wbyte;             // Written byte lane
	wire        wrap;              // Counter reaches period this tick
	wire        en_rise;           // Enable just went from low to high

	// =====================================================
	// Control fields
	// =====================================================
	assign enable     = control_r[`CTRL_EN_BIT];                 // R3 R4
	assign int_enable = control_r[`CTRL_INT_BIT];                // R3
	assign div_sel    = control_r[`CTRL_DIV_MSB:`CTRL_DIV_LSB];  // R3
	assign en_rise    = enable && !en_d_r;

	// =====================================================
	// Bus decode
	// =====================================================
	// Word aligned: index is the address over four
	assign wr_idx  = {2'b00, PADDR_I[7:2]};
	assign wbyte   = PWDATA_I[7:0];
	assign setup   = PSEL_I && !PENABLE_I;
	assign wr_done = PSEL_I && PENABLE_I && pready_r && PWRITE_I && !pslverr_r;

	// Read mux and address check
	always @* begin
		rdata_nxt = 8'h00;
		hit_nxt   = 1'b1;
		if (wr_idx == `PERIOD_HIGH_IDX) begin
			rdata_nxt = period_high_r;
		end else if (wr_idx == `PERIOD_LOW_IDX) begin
			rdata_nxt = period_low_r;
		end else if (wr_idx == `PULSE_HIGH_IDX) begin
			rdata_nxt = pulse_high_r;
		end else if (wr_idx == `PULSE_LOW_IDX) begin
			rdata_nxt = pulse_low_r;
		end else if (wr_idx == `CONTROL_IDX) begin
			rdata_nxt = control_r;
		end else if (wr_idx == `COUNT_HIGH_IDX) begin
			rdata_nxt = count_r[15:8];
		end else if (wr_idx == `COUNT_LOW_IDX) begin
			rdata_nxt = count_r[7:0];
		end else if (wr_idx == `STATUS_IDX) begin
			// Pending request and live waveform level
			rdata_nxt = {6'h00, pwm_r, irq_r};
		end else begin
			hit_nxt = 1'b0;
		end
	end

	// No wait state: ready and data are registered at setup
	always @(posedge MCLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			if (setup) begin
				// Unmapped address reads zero and flags an error
				pslverr_r <= !hit_nxt;
				prdata_r  <= {24'h000000, rdata_nxt};
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// =====================================================
	// Control register
	// =====================================================
	// Unused top bits always read zero
	always @(posedge MCLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			control_r <= `CONTROL_RESET;
			en_d_r    <= 1'b0;
		end else begin
			en_d_r <= enable;
			if (wr_done && wr_idx == `CONTROL_IDX) begin
				control_r <= wbyte & `CTRL_USED_MASK; // R3
			end
		end
	end

	// =====================================================
	// Byte registers and pair tracking
	// =====================================================
	// A pair becomes a staged value only when both bytes have
	// arrived; a lone byte waits, whatever order they come in
	always @(posedge MCLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			period_high_r  <= `VALUE_RESET_HIGH;   // R13
			period_low_r   <= `VALUE_RESET_LOW;
			pulse_high_r   <= `VALUE_RESET_HIGH;
			pulse_low_r    <= `VALUE_RESET_LOW;
			period_seen_r  <= 2'b00;
			pulse_seen_r   <= 2'b00;
			period_stage_r <= `VALUE_RESET;
			pulse_stage_r  <= `VALUE_RESET;
			period_pend_r  <= 1'b0;
			pulse_pend_r   <= 1'b0;
		end else begin
			// Period high byte
			if (wr_done && wr_idx == `PERIOD_HIGH_IDX) begin
				period_high_r <= wbyte;
				if (period_seen_r[0]) begin
					period_stage_r <= {wbyte, period_low_r}; // R11 R21
					period_pend_r  <= 1'b1;
					period_seen_r  <= 2'b00;
				end else begin
					period_seen_r[1] <= 1'b1;
				end
			end
			// Period low byte
			if (wr_done && wr_idx == `PERIOD_LOW_IDX) begin
				period_low_r <= wbyte;
				if (period_seen_r[1]) begin
					period_stage_r <= {period_high_r, wbyte}; // R11 R21
					period_pend_r  <= 1'b1;
					period_seen_r  <= 2'b00;
				end else begin
					period_seen_r[0] <= 1'b1;
				end
			end
			// Pulse width high byte
			if (wr_done && wr_idx == `PULSE_HIGH_IDX) begin
				pulse_high_r <= wbyte;
				if (pulse_seen_r[0]) begin
					pulse_stage_r <= {wbyte, pulse_low_r}; // R10 R21
					pulse_pend_r  <= 1'b1;
					pulse_seen_r  <= 2'b00;
				end else begin
					pulse_seen_r[1] <= 1'b1;
				end
			end
			// Pulse width low byte
			if (wr_done && wr_idx == `PULSE_LOW_IDX) begin
				pulse_low_r <= wbyte;
				if (pulse_seen_r[1]) begin
					pulse_stage_r <= {pulse_high_r, wbyte}; // R10 R21
					pulse_pend_r  <= 1'b1;
					pulse_seen_r  <= 2'b00;
				end else begin
					pulse_seen_r[0] <= 1'b1;
				end
			end
			// Enable edge takes raw bytes, so stale halves are dropped
			if (en_rise) begin
				period_seen_r <= 2'b00; // R12
				pulse_seen_r  <= 2'b00;
				period_pend_r <= 1'b0;
				pulse_pend_r  <= 1'b0;
			end else if (wrap && tick) begin
				// Staged values move to the running cycle at the wrap
				if (!(wr_done && period_seen_r != 2'b00 &&
				      (wr_idx == `PERIOD_HIGH_IDX || wr_idx == `PERIOD_LOW_IDX))) begin
					period_pend_r <= 1'b0;
				end
				if (!(wr_done && pulse_seen_r != 2'b00 &&
				      (wr_idx == `PULSE_HIGH_IDX || wr_idx == `PULSE_LOW_IDX))) begin
					pulse_pend_r <= 1'b0;
				end
			end
		end
	end

	// =====================================================
	// Prescaler
	// =====================================================
	clk_prescaler #(
		.CNT_W   (`DIV_CNT_WIDTH)
	) u_prescaler (
		.clk_i   (MCLK_I),
		.rst_n_i (rst_n_r),
		.sel_i   (div_sel),
		.run_i   (enable),
		.tick_o  (tick)
	);

	// =====================================================
	// Counter and active values
	// =====================================================
	// Period of zero is treated as a wrap on every tick
	assign wrap = ({1'b0, count_r} + 17'h00001) >= {1'b0, period_act_r}; // R7

	always @(posedge MCLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			count_r      <= 16'h0000;
			period_act_r <= `VALUE_RESET; // R13
			pulse_act_r  <= `VALUE_RESET;
		end else if (!enable) begin
			count_r <= 16'h0000; // R5
		end else if (en_rise) begin
			// Whatever the byte registers hold now defines the waveform
			count_r      <= 16'h0000;
			period_act_r <= {period_high_r, period_low_r}; // R12
			pulse_act_r  <= {pulse_high_r, pulse_low_r};
		end else if (tick) begin
			if (wrap) begin
				count_r <= 16'h0000; // R7
				// Only complete pairs reach the running cycle
				if (period_pend_r) begin
					period_act_r <= period_stage_r; // R9
				end
				if (pulse_pend_r) begin
					pulse_act_r <= pulse_stage_r; // R9
				end
			end else begin
				count_r <= count_r + 16'h0001; // R6
			end
		end
	end

	// =====================================================
	// Waveform
	// =====================================================
	// High from the wrap until the counter meets the pulse width;
	// the strict compare gives the low level at the match itself
	always @* begin
		if (!enable) begin
			pwm_nxt = 1'b0;
		end else if (pulse_act_r == `PULSE_ALL_ONES) begin
			pwm_nxt = 1'b1; // R17
		end else if (pulse_act_r == 16'h0000) begin
			pwm_nxt = 1'b0; // R16
		end else if (period_act_r <= pulse_act_r) begin
			pwm_nxt = 1'b1; // R15
		end else begin
			pwm_nxt = (count_r < pulse_act_r); // R7 R8
		end
	end

	always @(posedge MCLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pwm_r <= 1'b0;
		end else begin
			pwm_r <= pwm_nxt;
		end
	end

	// =====================================================
	// Interrupt request
	// =====================================================
	// A wrap in the same cycle as a clearing write still sets it
	always @(posedge MCLK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_r <= 1'b0;
		end else if (enable && tick && wrap && int_enable) begin
			irq_r <= 1'b1; // R18 R19 R22
		end else if (wr_done) begin
			irq_r <= 1'b0; // R20
		end
	end

	// =====================================================
	// Outputs
	// =====================================================
	assign PRDATA_O  = prdata_r;
	assign PREADY_O  = pready_r;
	assign PSLVERR_O = pslverr_r;
	assign PWM_O     = pwm_r;
	assign IRQ_O     = irq_r;

endmodule // pwm_gen
`default_nettype wire

// File: rtl/pwm_regs.vh
// Functional notes
// R1: Prescaler longest period is 128 clocks
// R2: Select codes 0..7 divide by 1..128
// R3: Control: bit0 enable, bit1 irq, 4:2 divider
// R4: Software sets enable before output modulates
// R5: Counter cleared while enable is low
// R6: 16-bit counter steps on each prescaled tick
// R7: Period value wraps counter, output set there
// R8: Counter equal to pulse width clears output
// R9: New values take effect after next wrap
// R10: Pulse width needs both bytes written first
// R11: Period needs both bytes written first
// R12: Enable rising edge loads stored bytes directly
// R13: Period and pulse width reset to zero
// R14: Divider select change acts at once
// R15: Period not above pulse width keeps output high
// R16: Zero pulse width keeps output low
// R17: All-ones pulse width keeps output high
// R18: Interrupt only when interrupt enable set
// R19: Interrupt set at every counter wrap
// R20: Any register write clears pending interrupt
// R21: Software writes each value as two bytes
// R22: Interrupt request held until cleared
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// =====================================================
// Register indices (byte address is four times these)
// =====================================================
`define PERIOD_HIGH_IDX     8'h10
`define PERIOD_LOW_IDX      8'h11
`define PULSE_HIGH_IDX      8'h12
`define PULSE_LOW_IDX       8'h13
`define CONTROL_IDX         8'h14
`define COUNT_HIGH_IDX      8'h15
`define COUNT_LOW_IDX       8'h16
`define STATUS_IDX          8'h17

// =====================================================
// Control field positions
// =====================================================
`define CTRL_EN_BIT         0
`define CTRL_INT_BIT        1
`define CTRL_DIV_LSB        2
`define CTRL_DIV_MSB        4
`define CTRL_USED_MASK      8'h1f

// =====================================================
// Reset values
// =====================================================
`define CONTROL_RESET       8'h00
`define VALUE_RESET         16'h0000
`define VALUE_RESET_HIGH    8'h00
`define VALUE_RESET_LOW     8'h00
`define PULSE_ALL_ONES      16'hffff

// =====================================================
// Timing counts
// =====================================================
`define DIV_MAX_CLOCKS      128
`define DIV_CNT_WIDTH       7

`endif

// File: rtl/clk_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.vh"

// =====================================================
// Clock prescaler: one-cycle tick every 2**sel clocks
// =====================================================
module clk_prescaler #(
	parameter CNT_W = `DIV_CNT_WIDTH
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// Divider select and enable
	input  wire [2:0]       sel_i,
	input  wire             run_i,
	// Tick output
	output wire             tick_o
);

	reg  [CNT_W-1:0] div_cnt_r;   // Divider, held at zero while stopped
	wire [CNT_W-1:0] div_mask;    // Low bits that must be zero

	// Mask of low bits for the selected ratio
	function [CNT_W-1:0] sel_mask;
		input [2:0] s;
		integer k;
		begin
			sel_mask = {CNT_W{1'b0}};
			for (k = 0; k < CNT_W; k = k + 1) begin
				if (k < s) begin
					sel_mask[k] = 1'b1;
				end
			end
		end
	endfunction

	assign div_mask = sel_mask(sel_i);

	// Divider counts only while the block runs, so a fresh enable starts aligned
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_r <= {CNT_W{1'b0}};
		end else if (!run_i) begin
			div_cnt_r <= {CNT_W{1'b0}};
		end else begin
			div_cnt_r <= div_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // R1
		end
	end

	// Select is decoded live, so a new ratio acts on the next tick
	assign tick_o = run_i && ((div_cnt_r & div_mask) == {CNT_W{1'b0}}); // R2 R14

endmodule // clk_prescaler
`default_nettype wire

// File: rtl/README_unused.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: sim/pwm_gen_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// Port-level checker for the pulse width generator
// =====================================================
module pwm_gen_monitor #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire logic              MCLK_I,
	input wire logic              RSTN_I,
	// APB slave
	input wire logic              PSEL_I,
	input wire logic              PENABLE_I,
	input wire logic              PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0]       PWDATA_I,
	input wire logic [31:0]       PRDATA_O,
	input wire logic              PREADY_O,
	input wire logic              PSLVERR_O,
	// Waveform and request
	input wire logic              PWM_O,
	input wire logic              IRQ_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);

	// =====================================================
	// Helper decode
	// =====================================================
	logic ien_r; // Shadow of the interrupt enable bit
	wire  setup   = PSEL_I && !PENABLE_I;                       // APB setup cycle
	wire  wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I; // Completed write
	wire  mapped  = PADDR_I[7:2] >= 6'h10 && PADDR_I[7:2] <= 6'h17; // Known index
	wire  ctl_wr  = wr_done && !PSLVERR_O && PADDR_I[7:2] == 6'h14; // Control write

	// Track interrupt enable so rises can be tied to it
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ien_r <= 1'b0;
		end else if (ctl_wr) begin
			ien_r <= PWDATA_I[1];
		end
	end

	// =====================================================
	// Assertions
	// =====================================================
	a_ready_after_setup: assert property (setup |=> PREADY_O)
		else $error("ready missing after setup");
	a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held too long");
	a_rdata_upper_zero: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_unmapped_err: assert property (setup && !mapped |=> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (setup && mapped |=> !PSLVERR_O)
		else $error("mapped access refused");
	a_irq_needs_en: assert property ($rose(IRQ_O) |-> $past(ien_r))
		else $error("request rose while masked");
	a_irq_sticky: assert property (IRQ_O && !wr_done |=> IRQ_O)
		else $error("request dropped without write");
	a_irq_write_clear: assert property (wr_done && !PSLVERR_O && !ien_r |=> !IRQ_O)
		else $error("request survived a write");
	a_pwm_off: assert property (ctl_wr && !PWDATA_I[0] |=> ##1 !PWM_O [*2])
		else $error("output high while disabled");

	// Main scenarios reached
	c_irq_rise: cover property ($rose(IRQ_O));
	c_pwm_rise: cover property ($rose(PWM_O));
	c_refused: cover property (PSLVERR_O);
endmodule // pwm_gen_monitor

bind pwm_gen pwm_gen_monitor #(.ADDR_W(ADDR_W)) i_mon (
	.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PWM_O(PWM_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.vh"
module tb;
	// =====================================================
	// Signals
	// =====================================================
	logic        clk;                 // System clock
	logic        rst_n;               // Active-low reset
	logic        psel;                // APB select
	logic        penable;             // APB enable
	logic        pwrite;              // APB direction
	logic [7:0]  paddr;               // APB byte address
	logic [31:0] pwdata;              // APB write data
	wire  [31:0] prdata;              // APB read data
	wire         pready;              // APB ready
	wire         pslverr;             // APB error
	wire         pwm;                 // Waveform
	wire         irq;                 // Interrupt request
	logic [31:0] rd;                  // Last read data
	int          mismatches = 0;      // Failed comparisons
	int          samples_checked = 0; // All comparisons
	int          cycles = 0;          // Watchdog count
	int          hi;                  // High cycles in a window
	int          n;                   // Wait count
	localparam logic [7:0] ctl = `CONTROL_IDX;
	localparam logic [7:0] ph  = `PERIOD_HIGH_IDX;
	localparam logic [7:0] pl  = `PERIOD_LOW_IDX;
	localparam logic [7:0] wh  = `PULSE_HIGH_IDX;
	localparam logic [7:0] wl  = `PULSE_LOW_IDX;

	pwm_gen #(.ADDR_W(8)) i_dut (
		.MCLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PWM_O(pwm), .IRQ_O(irq)
	);

	// =====================================================
	// Clock and watchdog
	// =====================================================
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Cut a hang short; the ceiling is well above the planned run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			$display("ERROR %0t watchdog expired", $time);
			close_out();
		end
	end

	// =====================================================
	// Tasks
	// =====================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer; waits for ready, then checks the error flag
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic xerr);
		int w;
		w = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx[5:0], 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		// Request stands until ready is seen high at a rising edge
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
			w++;
		end
		chk(w < 16, 1'b1, "ready wait");
		rd = prdata;
		chk(pslverr, xerr, "error flag");
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count high cycles of the waveform over a window
	task automatic measure(input int len);
		hi = 0;
		repeat (len) begin
			@(negedge clk);
			if (pwm === 1'b1) hi++;
		end
	endtask
	task automatic close_out();
		$display("TB: %0d mismatches, %0d checks", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// =====================================================
	// Main sequence
	// =====================================================
	initial begin
		psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; rst_n = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values, refused indices, unused control bits
		for (int i = 16; i < 24; i++) begin
			xfer(1'b0, i[7:0], 8'h00, 1'b0);
			chk(rd, 32'h0, "reset value");
		end
		xfer(1'b0, 8'h00, 8'h00, 1'b1);
		xfer(1'b1, 8'h3f, 8'hff, 1'b1);
		xfer(1'b1, ctl, 8'hfc, 1'b0);
		xfer(1'b0, ctl, 8'h00, 1'b0);
		chk(rd, 32'h1c, "control fields");
		$display("TB: register test done");
		// Enable with nothing written: stays low
		xfer(1'b1, ctl, 8'h01, 1'b0);
		measure(200);
		chk(hi, 0, "never written");
		// Raw bytes taken on enable, only low halves written
		xfer(1'b1, ctl, 8'h00, 1'b0);
		xfer(1'b1, pl, 8'h04, 1'b0);
		xfer(1'b1, wl, 8'h02, 1'b0);
		xfer(1'b1, ctl, 8'h01, 1'b0);
		repeat (8) @(negedge clk);
		measure(40);
		chk(hi, 20, "period 4 pulse 2");
		// Every divider code, changed while running
		for (int s = 0; s < 8; s++) begin
			xfer(1'b1, ctl, {3'b000, s[2:0], 2'b01}, 1'b0);
			repeat ((8 << s) + 4) @(negedge clk);
			measure(8 << s);
			chk(hi, 4 << s, "divider code");
		end
		xfer(1'b1, ctl, 8'h01, 1'b0);
		$display("TB: divider test done");
		// Half a pair has no effect until the other half lands
		xfer(1'b1, wl, 8'h03, 1'b0);
		repeat (12) @(negedge clk);
		measure(40);
		chk(hi, 20, "pulse half written");
		xfer(1'b1, wh, 8'h00, 1'b0);
		repeat (12) @(negedge clk);
		measure(40);
		chk(hi, 30, "pulse 3 applied");
		xfer(1'b1, pl, 8'h08, 1'b0);
		repeat (12) @(negedge clk);
		measure(40);
		chk(hi, 30, "period half written");
		xfer(1'b1, ph, 8'h00, 1'b0);
		repeat (20) @(negedge clk);
		measure(40);
		chk(hi, 15, "period 8 applied");
		// Boundary pulse widths against period 8
		xfer(1'b1, wl, 8'h08, 1'b0);
		xfer(1'b1, wh, 8'h00, 1'b0);
		repeat (20) @(negedge clk);
		measure(40);
		chk(hi, 40, "pulse equals period");
		xfer(1'b1, wh, 8'hff, 1'b0);
		xfer(1'b1, wl, 8'hff, 1'b0);
		repeat (20) @(negedge clk);
		measure(40);
		chk(hi, 40, "pulse all ones");
		xfer(1'b1, wh, 8'h00, 1'b0);
		xfer(1'b1, wl, 8'h00, 1'b0);
		repeat (20) @(negedge clk);
		measure(40);
		chk(hi, 0, "pulse zero");
		$display("TB: waveform test done");
		// Interrupt: raised, held, cleared by a write, masked
		xfer(1'b1, ctl, 8'h1f, 1'b0);
		n = 0;
		while (irq !== 1'b1 && n < 1400) begin
			@(negedge clk);
			n++;
		end
		chk(irq, 1'b1, "request at wrap");
		repeat (50) @(negedge clk);
		xfer(1'b0, `STATUS_IDX, 8'h00, 1'b0);
		chk(rd & 32'h1, 32'h1, "request pending");
		chk(irq, 1'b1, "read keeps request");
		xfer(1'b1, wl, 8'h04, 1'b0);
		@(negedge clk);
		chk(irq, 1'b0, "write clears request");
		xfer(1'b1, ctl, 8'h1d, 1'b0);
		repeat (2200) @(negedge clk);
		chk(irq, 1'b0, "masked request");
		// Disable clears the counter
		xfer(1'b1, ctl, 8'h00, 1'b0);
		xfer(1'b0, `COUNT_HIGH_IDX, 8'h00, 1'b0);
		chk(rd, 32'h0, "count high cleared");
		xfer(1'b0, `COUNT_LOW_IDX, 8'h00, 1'b0);
		chk(rd, 32'h0, "count low cleared");
		chk(pwm, 1'b0, "disabled output");
		$display("TB: interrupt test done");
		close_out();
	end
endmodule // tb
`default_nettype wire
